// ### common/lic_params.svh
`ifndef LIC_PARAMS_SVH
`define LIC_PARAMS_SVH

// Register byte offsets
`define LIC_ID_OFF        8'h00
`define LIC_TPR_OFF       8'h04
`define LIC_ARB_OFF       8'h08
`define LIC_PPR_OFF       8'h0c
`define LIC_EOI_OFF       8'h10
`define LIC_LDR_OFF       8'h14
`define LIC_DFR_OFF       8'h18
`define LIC_SVR_OFF       8'h1c
`define LIC_EXT_OFF       8'h20
`define LIC_CTL_OFF       8'h24
`define LIC_CMDL_OFF      8'h28
`define LIC_CMDH_OFF      8'h2c
`define LIC_TLVT_OFF      8'h30
`define LIC_TDIV_OFF      8'h34
`define LIC_TINIT_OFF     8'h38
`define LIC_TCUR_OFF      8'h3c
// Arrays, eight words each
`define LIC_IER_BASE      3'h2
`define LIC_IRR_BASE      3'h3
`define LIC_ISR_BASE      3'h4
`define LIC_TMR_BASE      3'h5

// Field positions
`define LIC_SVR_SWEN      8
`define LIC_SVR_FOCUS_DIS 9
`define LIC_CMD_LOGICAL   11
`define LIC_CMD_LEVEL     15
`define LIC_TLVT_MASK     16
`define LIC_TLVT_PERIODIC 17

// Reset values and other fixed constants
`define LIC_ID_RST        8'h00
`define LIC_SVR_RST       10'h0ff
`define LIC_TLVT_RST      18'h10000
`define LIC_IER_RST       256'hffffffff_ffffffff_ffffffff_ffffffff_ffffffff_ffffffff_ffffffff_ffffffff
`define LIC_BCAST_DEST    8'hff
`define LIC_SELF_ONLY     2'h1
`define LIC_SELF_ALL      2'h2
`define LIC_TIMER_RATIO   10'h002
`define LIC_RSVD_VEC_TOP  4'h0

`endif

// ### common/lic_pkg.sv
package lic_pkg;

	typedef enum logic [2:0] {
		LIC_MT_FIXED   = 3'h0,
		LIC_MT_LOWEST  = 3'h1,
		LIC_MT_SMI     = 3'h2,
		LIC_MT_RREAD   = 3'h3,
		LIC_MT_NMI     = 3'h4,
		LIC_MT_INIT    = 3'h5,
		LIC_MT_STARTUP = 3'h6,
		LIC_MT_EXTERNAL_INTERRUPT_TYPE  = 3'h7
	} lic_mtype_e;

	typedef struct packed {
		logic [7:0] vector;
		lic_mtype_e mtype;
		logic       level;
		logic       logical;
		logic [7:0] dest;
		logic       arb_won;
	} lic_msg_s;

	typedef struct packed {
		logic       smi;
		logic       nmi;
		logic       init;
		logic       startup;
		logic       external_interrupt_type;
		logic [7:0] vector;
	} lic_nv_s;

	typedef struct packed {
		logic [7:0] vector;
		lic_mtype_e mtype;
		logic       level;
		logic       logical;
		logic [7:0] dest;
	} lic_ipi_s;

	typedef struct packed {
		logic [7:0] vector;
		logic       valid;
		logic       spurious;
	} lic_ack_s;

endpackage

// ### design/lic_top.sv
// Operation
// - Flat logical: accept when any destination bit 7-0 is set in both.
// - Cluster logical: nibble 7-4 equal and some bit 3-0 common.
// - SMI, NMI, INIT, Startup, External go straight to core, not queued.
// - Fixed or lowest sets request bit of its vector; vectors 15-0 reserved.
// - Trigger-mode bit set for level, cleared for edge on queuing.
// - Same vector arriving while pending merges into one request.
// - Processor priority is max of task nibble and in-service nibble.
// - On core readiness, highest request moves to in-service.
// - End-of-interrupt write clears highest in-service bit.
// - Level-triggered completion broadcasts end-of-interrupt to peers.
// - With enable capability, disabled vectors stay pending, never serviced.
// - Task priority at or above level gives spurious vector, no in-service.
// - Fixed and non-vectored accepted without arbitration; remote read is not accepted.
// - Focus controller accepts lowest-priority unless focus checking disabled.
// - Without focus, lowest arbitration priority among peers accepts.
// - Arbitration priority from task, request and in-service nibbles.
// - With enable capability, arbitration vectors use enabled bits only.
// - Command low write emits interrupt from both command registers, except with the self-only shorthand.
// - Initial count write loads current count; decrements per divided tick.
// - At zero the timer raises its vector unless masked; periodic reloads.
// - Vector table message type decode: fixed, SMI, NMI, external.
// - After reset hardware disabled; only SMI, NMI, INIT, external accepted.
// - INIT resets all but identifier and extended control register.
// - Broadcast destination value is accepted in every mode.
`timescale 1ns/1ps
`include "lic_params.svh"

module lic_top #(
	parameter logic [9:0] TIMER_RATIO = `LIC_TIMER_RATIO
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              msg_valid,
	input  wire lic_pkg::lic_msg_s msg,
	input  wire logic              core_ack,
	output logic                   intr_pending,
	output lic_pkg::lic_ack_s      ack_out,
	output lic_pkg::lic_nv_s       nv_out,
	output logic                   eoi_bcast,
	output logic [7:0]             eoi_vector,
	output logic                   ipi_valid,
	output lic_pkg::lic_ipi_s      ipi_out,
	output logic [7:0]             arb_prio
);
	import lic_pkg::*;

	function automatic logic [8:0] lic_high(input logic [255:0] v);
		logic [8:0] r;
		r = 9'h000;
		for (int i = 0; i < 256; i++) begin
			if (v[i])
				r = {1'b1, 8'(i)};
		end
		return r;
	endfunction

	logic [7:0]   id_q, tpr_q, ldr_q, arb_q, ppr_q;
	logic         dfr_cluster_q, ext_cap_q, hw_en_q;
	logic [9:0]   svr_q;
	logic [19:0]  cmdl_q;
	logic [7:0]   cmdh_q;
	logic [17:0]  tlvt_q;
	logic [2:0]   tdiv_q;
	logic [31:0]  tinit_q, tcur_q;
	logic [9:0]   tick_cnt_q;
	logic [255:0] ier_q, irr_q, isr_q, tmr_q;
	logic [31:0]  prdata_q;
	logic         pready_q, pslverr_q;

	logic         wr_en, rd_en, init_hit;
	logic         sw_en, focus_dis;
	logic [255:0] svc_mask, irr_set, tm_set, tm_clr, irr_clr, isr_set, isr_clr;
	logic [8:0]   hi_req, hi_isr, arb_req, arb_isr;
	logic         tick, t_fire;
	logic         msg_hit, msg_vec_ok, msg_take;
	logic         svc_go, self_ipi;

	assign wr_en     = psel & penable & pready_q & pwrite & ~pslverr_q;
	assign rd_en     = psel & ~penable & ~pwrite;
	assign sw_en     = svr_q[`LIC_SVR_SWEN];
	assign focus_dis = svr_q[`LIC_SVR_FOCUS_DIS];
	assign svc_mask  = ext_cap_q ? ier_q : '1;

	// Priority encoders
	assign hi_req  = lic_high(irr_q & svc_mask);
	assign hi_isr  = lic_high(isr_q);
	assign arb_req = lic_high(irr_q & svc_mask);
	assign arb_isr = lic_high(isr_q & svc_mask);

	// Destination match
	always_comb begin
		logic bcast, lmatch, pmatch;
		bcast  = msg.dest == `LIC_BCAST_DEST;
		pmatch = msg.dest == id_q;
		if (dfr_cluster_q)
			lmatch = (msg.dest[7:4] == ldr_q[7:4]) && |(msg.dest[3:0] & ldr_q[3:0]);
		else
			lmatch = |(msg.dest & ldr_q);
		msg_hit = msg_valid & (bcast | (msg.logical ? lmatch : pmatch));
	end

	// Acceptance by type
	always_comb begin
		logic focus;
		focus = ~focus_dis & (isr_q[msg.vector] | irr_q[msg.vector]) &
		        (~ext_cap_q | ier_q[msg.vector]);
		msg_vec_ok = hw_en_q & sw_en & (msg.vector[7:4] != `LIC_RSVD_VEC_TOP);
		msg_take = 1'b0;
		init_hit = 1'b0;
		if (msg_hit) begin
			unique case (msg.mtype)
				LIC_MT_FIXED:   msg_take = msg_vec_ok;
				LIC_MT_LOWEST:  msg_take = msg_vec_ok & (focus | msg.arb_won);
				LIC_MT_RREAD:   msg_take = 1'b0;
				LIC_MT_STARTUP: msg_take = 1'b0;
				LIC_MT_SMI, LIC_MT_NMI, LIC_MT_INIT, LIC_MT_EXTERNAL_INTERRUPT_TYPE: msg_take = 1'b0;
			endcase
			init_hit = msg.mtype == LIC_MT_INIT;
		end
	end

	// Service decision
	assign svc_go = core_ack & hi_req[8] & (hi_req[7:4] > ppr_q[7:4]);
	assign self_ipi = wr_en & (paddr == `LIC_CMDL_OFF) &
	                  (pwdata[19:18] == `LIC_SELF_ONLY || pwdata[19:18] == `LIC_SELF_ALL) &
	                  hw_en_q & sw_en & (pwdata[7:4] != `LIC_RSVD_VEC_TOP);

	// Set and clear vectors for the bit arrays
	always_comb begin
		irr_set = '0;
		tm_set  = '0;
		tm_clr  = '0;
		irr_clr = '0;
		isr_set = '0;
		isr_clr = '0;
		if (msg_take) begin
			irr_set[msg.vector] = 1'b1;
			tm_set[msg.vector]  = msg.level;
			tm_clr[msg.vector]  = ~msg.level;
		end
		if (t_fire && lic_mtype_e'(tlvt_q[10:8]) == LIC_MT_FIXED && hw_en_q && sw_en &&
		    tlvt_q[7:4] != `LIC_RSVD_VEC_TOP) begin
			irr_set[tlvt_q[7:0]] = 1'b1;
			tm_clr[tlvt_q[7:0]]  = 1'b1;
		end
		if (self_ipi) begin
			irr_set[pwdata[7:0]] = 1'b1;
			tm_set[pwdata[7:0]]  = pwdata[`LIC_CMD_LEVEL];
			tm_clr[pwdata[7:0]]  = ~pwdata[`LIC_CMD_LEVEL];
		end
		if (svc_go) begin
			irr_clr[hi_req[7:0]] = 1'b1;
			isr_set[hi_req[7:0]] = 1'b1;
		end
		if (wr_en && paddr == `LIC_EOI_OFF && hi_isr[8])
			isr_clr[hi_isr[7:0]] = 1'b1;
	end

	// Bit arrays
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irr_q <= '0;
			isr_q <= '0;
			tmr_q <= '0;
		end else if (init_hit) begin
			irr_q <= '0;
			isr_q <= '0;
			tmr_q <= '0;
		end else begin
			irr_q <= (irr_q & ~irr_clr) | irr_set;
			isr_q <= (isr_q & ~isr_clr) | isr_set;
			tmr_q <= (tmr_q & ~tm_clr) | tm_set;
		end
	end

	// Enable array
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ier_q <= `LIC_IER_RST;
		end else if (init_hit) begin
			ier_q <= `LIC_IER_RST;
		end else if (wr_en && paddr[7:5] == `LIC_IER_BASE) begin
			ier_q[{paddr[4:2], 5'h00} +: 32] <= pwdata;
		end
	end

	// Priorities
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ppr_q <= 8'h00;
			arb_q <= 8'h00;
		end else begin
			if (tpr_q[7:4] >= hi_isr[7:4])
				ppr_q <= {tpr_q[7:4], 4'h0};
			else
				ppr_q <= {hi_isr[7:4], 4'h0};
			if (tpr_q[7:4] >= arb_req[7:4] && tpr_q[7:4] > arb_isr[7:4])
				arb_q <= tpr_q;
			else if (arb_req[7:4] > arb_isr[7:4])
				arb_q <= {arb_req[7:4], 4'h0};
			else
				arb_q <= {arb_isr[7:4], 4'h0};
		end
	end

	// Core-facing outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			intr_pending <= 1'b0;
			ack_out      <= '0;
			nv_out       <= '0;
		end else begin
			intr_pending <= hi_req[8] & (hi_req[7:4] > ppr_q[7:4]);
			ack_out      <= '0;
			nv_out       <= '0;
			if (core_ack) begin
				ack_out.valid <= 1'b1;
				if (svc_go) begin
					ack_out.vector <= hi_req[7:0];
				end else begin
					ack_out.vector   <= svr_q[7:0];
					ack_out.spurious <= 1'b1;
				end
			end
			if (msg_hit) begin
				nv_out.smi     <= msg.mtype == LIC_MT_SMI;
				nv_out.nmi     <= msg.mtype == LIC_MT_NMI;
				nv_out.init    <= msg.mtype == LIC_MT_INIT;
				nv_out.startup <= msg.mtype == LIC_MT_STARTUP && hw_en_q && sw_en;
				nv_out.external_interrupt_type  <= msg.mtype == LIC_MT_EXTERNAL_INTERRUPT_TYPE;
				nv_out.vector  <= msg.vector;
			end
			if (t_fire && !init_hit) begin
				unique case (lic_mtype_e'(tlvt_q[10:8]))
					LIC_MT_SMI:    nv_out.smi    <= 1'b1;
					LIC_MT_NMI:    nv_out.nmi    <= 1'b1;
					LIC_MT_EXTERNAL_INTERRUPT_TYPE: nv_out.external_interrupt_type <= 1'b1;
					default: ;
				endcase
			end
		end
	end

	// End-of-interrupt propagation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eoi_bcast  <= 1'b0;
			eoi_vector <= 8'h00;
		end else begin
			eoi_bcast <= |(isr_clr & tmr_q);
			if (|isr_clr)
				eoi_vector <= hi_isr[7:0];
		end
	end

	// Outgoing command interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ipi_valid <= 1'b0;
			ipi_out   <= '0;
		end else begin
			ipi_valid <= wr_en & (paddr == `LIC_CMDL_OFF) & ~init_hit &
			             (pwdata[19:18] != `LIC_SELF_ONLY);
			if (wr_en && paddr == `LIC_CMDL_OFF) begin
				ipi_out.vector  <= pwdata[7:0];
				ipi_out.mtype   <= lic_mtype_e'(pwdata[10:8]);
				ipi_out.logical <= pwdata[`LIC_CMD_LOGICAL];
				ipi_out.level   <= pwdata[`LIC_CMD_LEVEL];
				ipi_out.dest    <= cmdh_q;
			end
		end
	end

	// Timer tick divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tick_cnt_q <= 10'h000;
		else if (tick || init_hit)
			tick_cnt_q <= 10'h000;
		else
			tick_cnt_q <= tick_cnt_q + 10'h001;
	end
	assign tick = tick_cnt_q == 10'((TIMER_RATIO << tdiv_q) - 10'h001);

	// Timer count
	assign t_fire = tick & (tcur_q == 32'h0000_0001) & ~tlvt_q[`LIC_TLVT_MASK];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tcur_q <= 32'h0000_0000;
		end else if (init_hit) begin
			tcur_q <= 32'h0000_0000;
		end else if (wr_en && paddr == `LIC_TINIT_OFF) begin
			tcur_q <= pwdata;
		end else if (tick && tcur_q != 32'h0000_0000) begin
			if (tcur_q == 32'h0000_0001 && tlvt_q[`LIC_TLVT_PERIODIC])
				tcur_q <= tinit_q;
			else
				tcur_q <= tcur_q - 32'h0000_0001;
		end
	end

	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			id_q          <= `LIC_ID_RST;
			ext_cap_q     <= 1'b0;
			tpr_q         <= 8'h00;
			ldr_q         <= 8'h00;
			dfr_cluster_q <= 1'b0;
			svr_q         <= `LIC_SVR_RST;
			hw_en_q       <= 1'b0;
			cmdl_q        <= 20'h00000;
			cmdh_q        <= 8'h00;
			tlvt_q        <= `LIC_TLVT_RST;
			tdiv_q        <= 3'h0;
			tinit_q       <= 32'h0000_0000;
		end else if (init_hit) begin
			tpr_q         <= 8'h00;
			ldr_q         <= 8'h00;
			dfr_cluster_q <= 1'b0;
			svr_q         <= `LIC_SVR_RST;
			hw_en_q       <= 1'b0;
			cmdl_q        <= 20'h00000;
			cmdh_q        <= 8'h00;
			tlvt_q        <= `LIC_TLVT_RST;
			tdiv_q        <= 3'h0;
			tinit_q       <= 32'h0000_0000;
		end else if (wr_en) begin
			unique case (paddr)
				`LIC_ID_OFF:    id_q          <= pwdata[7:0];
				`LIC_TPR_OFF:   tpr_q         <= pwdata[7:0];
				`LIC_LDR_OFF:   ldr_q         <= pwdata[7:0];
				`LIC_DFR_OFF:   dfr_cluster_q <= pwdata[0];
				`LIC_SVR_OFF:   svr_q         <= pwdata[9:0];
				`LIC_EXT_OFF:   ext_cap_q     <= pwdata[0];
				`LIC_CTL_OFF:   hw_en_q       <= pwdata[0];
				`LIC_CMDL_OFF:  cmdl_q        <= pwdata[19:0];
				`LIC_CMDH_OFF:  cmdh_q        <= pwdata[7:0];
				`LIC_TLVT_OFF:  tlvt_q        <= pwdata[17:0];
				`LIC_TDIV_OFF:  tdiv_q        <= pwdata[2:0];
				`LIC_TINIT_OFF: tinit_q       <= pwdata;
				default: ;
			endcase
		end
	end

	// APB read data and handshake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= psel & ~penable & ~pready_q;
			pslverr_q <= 1'b0;
			if (psel && !penable) begin
				pslverr_q <= paddr[1:0] != 2'h0 || paddr > 8'hbc;
			end
			if (rd_en) begin
				prdata_q <= 32'h0000_0000;
				unique case ((paddr[1:0] != 2'h0) ? 3'h7 : paddr[7:5])
					`LIC_IER_BASE: prdata_q <= ier_q[{paddr[4:2], 5'h00} +: 32];
					`LIC_IRR_BASE: prdata_q <= irr_q[{paddr[4:2], 5'h00} +: 32];
					`LIC_ISR_BASE: prdata_q <= isr_q[{paddr[4:2], 5'h00} +: 32];
					`LIC_TMR_BASE: prdata_q <= tmr_q[{paddr[4:2], 5'h00} +: 32];
					default: begin
						unique case (paddr)
							`LIC_ID_OFF:    prdata_q <= {24'h0, id_q};
							`LIC_TPR_OFF:   prdata_q <= {24'h0, tpr_q};
							`LIC_ARB_OFF:   prdata_q <= {24'h0, arb_q};
							`LIC_PPR_OFF:   prdata_q <= {24'h0, ppr_q};
							`LIC_LDR_OFF:   prdata_q <= {24'h0, ldr_q};
							`LIC_DFR_OFF:   prdata_q <= {31'h0, dfr_cluster_q};
							`LIC_SVR_OFF:   prdata_q <= {22'h0, svr_q};
							`LIC_EXT_OFF:   prdata_q <= {31'h0, ext_cap_q};
							`LIC_CTL_OFF:   prdata_q <= {31'h0, hw_en_q};
							`LIC_CMDL_OFF:  prdata_q <= {12'h0, cmdl_q};
							`LIC_CMDH_OFF:  prdata_q <= {24'h0, cmdh_q};
							`LIC_TLVT_OFF:  prdata_q <= {14'h0, tlvt_q};
							`LIC_TDIV_OFF:  prdata_q <= {29'h0, tdiv_q};
							`LIC_TINIT_OFF: prdata_q <= tinit_q;
							`LIC_TCUR_OFF:  prdata_q <= tcur_q;
							default:        prdata_q <= 32'h0000_0000;
						endcase
					end
				endcase
			end
		end
	end

	assign prdata   = prdata_q;
	assign pready   = pready_q;
	assign pslverr  = pslverr_q;
	assign arb_prio = arb_q;

endmodule

// ### test/lic_top_asserts.sv
`timescale 1ns/1ps
module lic_top_asserts (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              msg_valid,
	input wire lic_pkg::lic_msg_s msg,
	input wire logic              core_ack,
	input wire lic_pkg::lic_ack_s ack_out,
	input wire lic_pkg::lic_nv_s  nv_out,
	input wire logic              eoi_bcast,
	input wire logic              ipi_valid,
	input wire logic [7:0]        arb_prio
);
	import lic_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wdone;
	assign wdone = psel && penable && pready && pwrite;
	property p_rdy; psel && !penable |=> pready; endproperty
	property p_one; pready |=> !pready; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_ack; core_ack |-> ##1 ack_out.valid; endproperty
	property p_nmi;
		msg_valid && msg.mtype == LIC_MT_NMI && msg.dest == 8'hff |=> nv_out.nmi;
	endproperty
	property p_eoi; eoi_bcast |-> $past(wdone && paddr == 8'h10); endproperty
	property p_ipi; ipi_valid |-> $past(wdone && paddr == 8'h28); endproperty
	property p_ip1; ipi_valid |=> !ipi_valid; endproperty
	property p_ini; nv_out.init |-> ##1 arb_prio == 8'h00; endproperty
	a_rdy: assert property (p_rdy) else $error("pready late");
	a_one: assert property (p_one) else $error("pready too long");
	a_err: assert property (p_err) else $error("pslverr without pready");
	a_ack: assert property (p_ack) else $error("no ack answer");
	a_nmi: assert property (p_nmi) else $error("nmi not passed");
	a_eoi: assert property (p_eoi) else $error("eoi pulse uncaused");
	a_ipi: assert property (p_ipi) else $error("ipi uncaused");
	a_ip1: assert property (p_ip1) else $error("ipi too long");
	a_ini: assert property (p_ini) else $error("init left state");
	cover property (ack_out.valid && ack_out.spurious);
	cover property (eoi_bcast);
	cover property (nv_out.init);
endmodule
bind lic_top lic_top_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .msg_valid(msg_valid), .msg(msg), .core_ack(core_ack),
	.ack_out(ack_out), .nv_out(nv_out), .eoi_bcast(eoi_bcast),
	.ipi_valid(ipi_valid), .arb_prio(arb_prio));

// ### test/lic_fabric_model.sv
`timescale 1ns/1ps
module lic_fabric_model (
	input  wire logic         pclk,
	output logic              msg_valid,
	output lic_pkg::lic_msg_s msg,
	output logic              core_ack
);
	import lic_pkg::*;
	initial begin
		msg_valid = 1'b0;
		msg       = '0;
		core_ack  = 1'b0;
	end
	// Released fields show inverted
	task automatic send(input lic_mtype_e t, input logic lg, input logic [7:0] d,
			input logic [7:0] v, input logic lv, input logic won);
		msg_valid <= 1'b1;
		msg       <= '{v, t, lv, lg, d, won};
		@(posedge pclk);
		msg_valid <= 1'b0;
		msg       <= lic_msg_s'(~{v, t, lv, lg, d, won});
		repeat (2) @(posedge pclk);
	endtask
	task automatic ack(input int w);
		repeat (w) @(posedge pclk);
		core_ack <= 1'b1;
		@(posedge pclk);
		core_ack <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
endmodule

// ### test/lic_top_tb.sv
`timescale 1ns/1ps
`define TB_CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
	num_errors++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module lic_top_tb;
	import lic_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r, r2;
	logic        pready, pslverr, e, msg_valid, core_ack, intr_pending;
	logic        eoi_bcast, ipi_valid;
	logic [7:0]  eoi_vector, arb_prio, eoi_l;
	lic_msg_s    msg;
	lic_ack_s    ack_out, ack_l;
	lic_nv_s     nv_out, nv_l;
	lic_ipi_s    ipi_out, ipi_l;
	int          n_ipi = 0, n_eoi = 0, num_errors = 0, n_tests = 0, cycles = 0;
	lic_mtype_e  nt [4] = '{LIC_MT_SMI, LIC_MT_NMI, LIC_MT_STARTUP, LIC_MT_EXTERNAL_INTERRUPT_TYPE};
	logic [4:0]  nb [4] = '{5'h10, 5'h08, 5'h02, 5'h01};
	lic_top #(.TIMER_RATIO(10'h001)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .msg_valid(msg_valid),
		.msg(msg), .core_ack(core_ack), .intr_pending(intr_pending), .ack_out(ack_out),
		.nv_out(nv_out), .eoi_bcast(eoi_bcast), .eoi_vector(eoi_vector),
		.ipi_valid(ipi_valid), .ipi_out(ipi_out), .arb_prio(arb_prio));
	lic_fabric_model fab_u (.pclk(pclk), .msg_valid(msg_valid), .msg(msg),
		.core_ack(core_ack));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (ack_out.valid === 1'b1) ack_l <= ack_out;
		if (nv_out[12:8] != 5'h0) nv_l <= nv_out;
		if (ipi_valid === 1'b1) begin
			ipi_l <= ipi_out;
			n_ipi <= n_ipi + 1;
		end
		if (eoi_bcast === 1'b1) begin
			eoi_l <= eoi_vector;
			n_eoi <= n_eoi + 1;
		end
		if (cycles == 8000) begin
			num_errors++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] x, input string nm);
		apb(1'b0, a, 32'h0);
		`TB_CHK(nm, x, r);
	endtask
	task automatic bchk(input logic [2:0] b, input logic [7:0] v, input logic x);
		apb(1'b0, {b, v[7:5], 2'b00}, 32'h0);
		`TB_CHK("bit", x, r[v[4:0]]);
	endtask
	task automatic q(input lic_mtype_e t, input logic [7:0] d, input logic [7:0] v,
			input logic lv, input logic won, input logic x);
		fab_u.send(t, 1'b1, d, v, lv, won);
		bchk(3'h3, v, x);
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(8'h1c, 32'h0ff, "svr");
		rchk(8'h30, 32'h10000, "lvt");
		rchk(8'h40, 32'hffffffff, "ier");
		rchk(8'h24, 32'h0, "hwen");
		rchk(8'hc0, 32'h0, "unmap");
		`TB_CHK("slverr", 1'b1, e);
		wr(8'h41, 32'h0);
		`TB_CHK("werr", 1'b1, e);
		rchk(8'h41, 32'h0, "rmis");
		rchk(8'h40, 32'hffffffff, "ierk");
		wr(8'h08, 32'hff);
		rchk(8'h08, 32'h0, "arb_ro");
		q(LIC_MT_FIXED, 8'hff, 8'h50, 1'b0, 1'b0, 1'b0);
		wr(8'h24, 32'h1);
		wr(8'h1c, 32'h1ff);
		wr(8'h14, 32'h35);
		q(LIC_MT_FIXED, 8'h10, 8'h40, 1'b1, 1'b0, 1'b1);
		q(LIC_MT_FIXED, 8'h0a, 8'h41, 1'b0, 1'b0, 1'b0);
		wr(8'h18, 32'h1);
		q(LIC_MT_FIXED, 8'h31, 8'h42, 1'b0, 1'b0, 1'b1);
		q(LIC_MT_FIXED, 8'h41, 8'h43, 1'b0, 1'b0, 1'b0);
		q(LIC_MT_FIXED, 8'h3a, 8'h44, 1'b0, 1'b0, 1'b0);
		q(LIC_MT_FIXED, 8'hff, 8'h3f, 1'b0, 1'b0, 1'b1);
		q(LIC_MT_FIXED, 8'hff, 8'h05, 1'b0, 1'b0, 1'b0);
		q(LIC_MT_FIXED, 8'h31, 8'h42, 1'b0, 1'b0, 1'b1);
		wr(8'h18, 32'h0);
		wr(8'h00, 32'h07);
		fab_u.send(LIC_MT_FIXED, 1'b0, 8'h07, 8'h25, 1'b0, 1'b0);
		bchk(3'h3, 8'h25, 1'b1);
		fab_u.send(LIC_MT_FIXED, 1'b0, 8'h35, 8'h26, 1'b0, 1'b0);
		bchk(3'h3, 8'h26, 1'b0);
		bchk(3'h5, 8'h40, 1'b1);
		bchk(3'h5, 8'h42, 1'b0);
		`TB_CHK("pend", 1'b1, intr_pending);
		rchk(8'h08, 32'h40, "arb");
		`TB_CHK("arbp", 8'h40, arb_prio);
		fab_u.ack(0);
		`TB_CHK("ack", {8'h42, 2'b10}, ack_l);
		bchk(3'h4, 8'h42, 1'b1);
		bchk(3'h3, 8'h42, 1'b0);
		wr(8'h04, 32'h5c);
		apb(1'b0, 8'h0c, 32'h0);
		`TB_CHK("ppr", 4'h5, r[7:4]);
		rchk(8'h08, 32'h5c, "arbt");
		wr(8'h04, 32'h0);
		fab_u.ack(3);
		`TB_CHK("spur", {8'hff, 2'b11}, ack_l);
		bchk(3'h4, 8'h40, 1'b0);
		wr(8'h10, 32'h0);
		bchk(3'h4, 8'h42, 1'b0);
		`TB_CHK("eoie", 0, n_eoi);
		fab_u.ack(0);
		`TB_CHK("next", {8'h40, 2'b10}, ack_l);
		wr(8'h10, 32'h0);
		repeat (2) @(posedge pclk);
		`TB_CHK("eoil", 1, n_eoi);
		`TB_CHK("eoiv", 8'h40, eoi_l);
		wr(8'h2c, 32'h12);
		wr(8'h28, 32'h860);
		repeat (2) @(posedge pclk);
		`TB_CHK("ipin", 1, n_ipi);
		`TB_CHK("ipi", {8'h60, LIC_MT_FIXED, 1'b0, 1'b1, 8'h12}, ipi_l);
		wr(8'h28, 32'h40070);
		bchk(3'h3, 8'h70, 1'b1);
		`TB_CHK("ipis", 1, n_ipi);
		wr(8'h30, 32'h80);
		wr(8'h38, 32'h8);
		apb(1'b0, 8'h3c, 32'h0);
		`TB_CHK("trun", 1'b1, r > 0 && r < 8);
		repeat (12) @(posedge pclk);
		rchk(8'h3c, 32'h0, "tstop");
		bchk(3'h3, 8'h80, 1'b1);
		wr(8'h30, 32'h30081);
		wr(8'h38, 32'h5);
		repeat (12) @(posedge pclk);
		apb(1'b0, 8'h3c, 32'h0);
		r2 = r;
		apb(1'b0, 8'h3c, 32'h0);
		`TB_CHK("trel", 1'b1, (r | r2) != 0 && r <= 5 && r2 <= 5);
		bchk(3'h3, 8'h81, 1'b0);
		wr(8'h34, 32'h1);
		wr(8'h38, 32'h64);
		apb(1'b0, 8'h3c, 32'h0);
		r2 = r;
		repeat (40) @(posedge pclk);
		apb(1'b0, 8'h3c, 32'h0);
		`TB_CHK("tdiv", 1'b1, r2 - r >= 20 && r2 - r <= 22);
		wr(8'h30, 32'h400);
		wr(8'h38, 32'h2);
		repeat (8) @(posedge pclk);
		`TB_CHK("tnmi", 5'h08, nv_l[12:8]);
		wr(8'h38, 32'h0);
		q(LIC_MT_LOWEST, 8'h10, 8'ha0, 1'b0, 1'b0, 1'b0);
		q(LIC_MT_LOWEST, 8'h10, 8'ha0, 1'b0, 1'b1, 1'b1);
		fab_u.ack(0);
		`TB_CHK("ackl", {8'ha0, 2'b10}, ack_l);
		q(LIC_MT_LOWEST, 8'h10, 8'ha0, 1'b0, 1'b0, 1'b1);
		wr(8'h10, 32'h0);
		wr(8'h20, 32'h1);
		wr(8'h54, 32'hfffffffe);
		rchk(8'h08, 32'h80, "arbe");
		fab_u.ack(0);
		`TB_CHK("acke", {8'h80, 2'b10}, ack_l);
		bchk(3'h3, 8'ha0, 1'b1);
		foreach (nt[i]) begin
			fab_u.send(nt[i], 1'b1, 8'hff, 8'h33, 1'b0, 1'b0);
			`TB_CHK("nv", nb[i], nv_l[12:8]);
		end
		bchk(3'h3, 8'h33, 1'b0);
		fab_u.send(LIC_MT_INIT, 1'b1, 8'hff, 8'h00, 1'b0, 1'b0);
		`TB_CHK("init", 5'h04, nv_l[12:8]);
		rchk(8'h24, 32'h0, "ihw");
		rchk(8'h20, 32'h1, "iext");
		bchk(3'h3, 8'h70, 1'b0);
		wr(8'h1c, 32'h1ff);
		q(LIC_MT_FIXED, 8'hff, 8'h90, 1'b0, 1'b0, 1'b0);
		close_out();
	end
endmodule
